// ==== core/shamac_params.svh ====
// Constants of the single-block hash engine
`ifndef SHAMAC_PARAMS_SVH
`define SHAMAC_PARAMS_SVH

// ****************************************
// Initial working words
// ****************************************
`define SHAMAC_INIT_A     32'h67452301
`define SHAMAC_INIT_B     32'hEFCDAB89
`define SHAMAC_INIT_C     32'h98BADCFE
`define SHAMAC_INIT_D     32'h10325476
`define SHAMAC_INIT_E     32'hC3D2E1F0

// ****************************************
// Round constants and group limits
// ****************************************
`define SHAMAC_K0         32'h5A827999
`define SHAMAC_K1         32'h6ED9EBA1
`define SHAMAC_K2         32'h8F1BBCDC
`define SHAMAC_K3         32'hCA62C1D6
`define SHAMAC_END_G0     7'h13
`define SHAMAC_END_G1     7'h27
`define SHAMAC_END_G2     7'h3B
`define SHAMAC_LAST_ROUND 7'h4F
`define SHAMAC_MSG_WORDS  16

// ****************************************
// Rotation counts
// ****************************************
`define SHAMAC_ROT_A      5
`define SHAMAC_ROT_B      30
`define SHAMAC_ROT_W      1

// ****************************************
// Schedule taps (positions in a 16-word window)
// ****************************************
`define SHAMAC_TAP_3      13
`define SHAMAC_TAP_8      8
`define SHAMAC_TAP_14     2
`define SHAMAC_TAP_16     0

// ****************************************
// Host-side wait after the read data (us)
// ****************************************
`define SHAMAC_WAIT_US    2000
`define SHAMAC_CLK_MHZ    200

`endif

// ==== core/shamac_pkg.sv ====
// Types shared by the hash engine files
package shamac_pkg;

  // Engine states
  typedef enum logic [1:0] {
    SHAMAC_IDLE = 2'b00,
    SHAMAC_RUN  = 2'b01,
    SHAMAC_DONE = 2'b10
  } shamac_state_type;

  // Purpose of a computation
  typedef enum logic {
    SHAMAC_OP_CODE   = 1'b0,
    SHAMAC_OP_SECRET = 1'b1
  } shamac_op_type;

  // Five working words
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    logic [31:0] e;
  } shamac_work_type;

  // Start request with its operation
  typedef struct packed {
    logic          start;
    shamac_op_type op;
  } shamac_req_type;

endpackage

// ==== core/shamac_round.sv ====
// One combinational round of the compression function
`timescale 1ns/10ps
`include "shamac_params.svh"

module shamac_round
  import shamac_pkg::*;
(
  // Round inputs
  input  wire logic [6:0]      round_index,
  input  wire shamac_work_type work_in,
  input  wire logic [31:0]     sched_word,
  // Round output
  output shamac_work_type      work_out,
  output logic [31:0]          round_sum
);

  // ****************************************
  // Round function and constant
  // ****************************************
  logic [31:0] func_val;   // Selected boolean function
  logic [31:0] konst;      // Selected constant
  logic [31:0] rot_a;      // A rotated by five
  logic [31:0] rot_b;      // B rotated by thirty

  // Function chosen by round group
  always_comb begin
    if (round_index <= `SHAMAC_END_G0) begin
      func_val = (work_in.b & work_in.c) | (~work_in.b & work_in.d);
      konst    = `SHAMAC_K0;
    end else if (round_index <= `SHAMAC_END_G1) begin
      func_val = work_in.b ^ work_in.c ^ work_in.d;
      konst    = `SHAMAC_K1;
    end else if (round_index <= `SHAMAC_END_G2) begin
      func_val = (work_in.b & work_in.c) | (work_in.b & work_in.d)
               | (work_in.c & work_in.d);
      konst    = `SHAMAC_K2;
    end else begin
      func_val = work_in.b ^ work_in.c ^ work_in.d;
      konst    = `SHAMAC_K3;
    end
  end

  // Left rotations, top bits wrap to bottom
  assign rot_a = {work_in.a[31-`SHAMAC_ROT_A:0], work_in.a[31:32-`SHAMAC_ROT_A]};
  assign rot_b = {work_in.b[31-`SHAMAC_ROT_B:0], work_in.b[31:32-`SHAMAC_ROT_B]};

  // Sum truncated to 32 bits, carry discarded
  assign round_sum = rot_a + func_val + sched_word + konst + work_in.e;

  // Word shift
  always_comb begin
    work_out.e = work_in.d;
    work_out.d = work_in.c;
    work_out.c = rot_b;
    work_out.b = work_in.a;
    work_out.a = round_sum;
  end

endmodule

// ==== core/shamac_engine.sv ====
// Single-block hash engine producing a code or a new secret
// How it works
// - Takes sixteen 32-bit message words per block
// - Additions are modulo two to thirty-two
// - Rotations are circular to the left
// - Round function chosen by round group
// - Schedule: message words, then rotated XOR taps
// - Round constant chosen by round group
// - Working words start from fixed values
// - Round sum then shift of working words
// - All eighty rounds run in order
// - Code is A,B,C,D,E without feed-forward
// - Secret mode copies E and D to secret
// - Code never shown in secret mode
// - Finish well before host waits two ms
`timescale 1ns/10ps
`include "shamac_params.svh"

module shamac_engine
  import shamac_pkg::*;
#(
  parameter int WORD_W = 32,
  parameter int ROUNDS = 80
)(
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  // Command side
  input  wire shamac_req_type               req,
  input  wire logic [16*WORD_W-1:0]         message,
  // Results
  output logic                              busy,
  output logic                              done,
  output logic [5*WORD_W-1:0]               authentication_code,
  output logic                              code_valid,
  output logic [2*WORD_W-1:0]               secret,
  output logic                              secret_load
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (WORD_W != 32) begin : g_bad_width
    $error("Only 32-bit words are supported");
  end
  if (ROUNDS != 80) begin : g_bad_rounds
    $error("Only eighty rounds are supported");
  end

  // Host wait in cycles, rounded down
  localparam int WAIT_CYC = `SHAMAC_WAIT_US * `SHAMAC_CLK_MHZ;

  // The host reads the result only after its fixed wait, so the whole
  // run plus the done edge must fit well inside that wait
  if (ROUNDS + 1 >= WAIT_CYC) begin : g_too_slow
    $error("Engine cannot finish within the host wait");
  end

  // ****************************************
  // State
  // ****************************************
  shamac_state_type  state;        // Engine state
  shamac_state_type  next_state;
  shamac_op_type     op;           // Operation latched at start
  shamac_op_type     next_op;
  logic [6:0]        round;        // Current round index
  logic [6:0]        next_round;
  shamac_work_type   work;         // Working words
  shamac_work_type   next_work;
  logic [31:0]       win [0:15];   // Schedule window, oldest first
  logic [31:0]       next_win [0:15];
  logic [159:0]      next_code;
  logic              next_valid;
  logic [63:0]       next_secret;
  logic              next_load;
  logic              next_done;
  logic              next_busy;

  // Round datapath signals
  shamac_work_type   work_rnd;     // Words after this round
  logic [31:0]       sched;        // Schedule word for this round
  logic [31:0]       sched_new;    // Extended word
  logic [31:0]       tap_xor;      // XOR of the four taps
  logic [31:0]       rsum;         // Round sum

  // ****************************************
  // Schedule extension
  // ****************************************
  // Taps at t-3, t-8, t-14, t-16 in the window
  assign tap_xor   = win[`SHAMAC_TAP_3] ^ win[`SHAMAC_TAP_8] ^ win[`SHAMAC_TAP_14] ^ win[`SHAMAC_TAP_16];
  assign sched_new = {tap_xor[31-`SHAMAC_ROT_W:0], tap_xor[31]};
  // Rounds 0..15 use message words directly
  assign sched     = (round < 7'(`SHAMAC_MSG_WORDS)) ? win[round[3:0]] : sched_new;

  // ****************************************
  // Round instance
  // ****************************************
  shamac_round u_round (
    .round_index (round),
    .work_in     (work),
    .sched_word  (sched),
    .work_out    (work_rnd),
    .round_sum   (rsum)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Every register holds by default; only the active branch moves it.
  // The secret load strobe defaults low so it lasts a single cycle.
  always_comb begin
    next_state  = state;
    next_op     = op;
    next_round  = round;
    next_work   = work;
    next_code   = authentication_code;
    next_valid  = code_valid;
    next_secret = secret;
    next_load   = 1'b0;
    next_done   = done;
    next_busy   = busy;
    for (int i = 0; i < 16; i++) begin
      next_win[i] = win[i];
    end
    case (state)
      SHAMAC_IDLE, SHAMAC_DONE: begin
        if (req.start) begin
          // Load block and initial words
          for (int i = 0; i < 16; i++) begin
            next_win[i] = message[(15-i)*32 +: 32];
          end
          next_work.a = `SHAMAC_INIT_A;
          next_work.b = `SHAMAC_INIT_B;
          next_work.c = `SHAMAC_INIT_C;
          next_work.d = `SHAMAC_INIT_D;
          next_work.e = `SHAMAC_INIT_E;
          next_op     = req.op;
          next_round  = 7'h00;
          next_state  = SHAMAC_RUN;
          next_done   = 1'b0;
          next_busy   = 1'b1;
          next_valid  = 1'b0;
          next_code   = '0;
        end
      end
      SHAMAC_RUN: begin
        next_work = work_rnd;
        // Slide window once the message words are consumed
        if (round >= 7'(`SHAMAC_MSG_WORDS) - 7'h01) begin
          for (int i = 0; i < 15; i++) begin
            next_win[i] = win[i+1];
          end
          next_win[15] = (round < 7'(`SHAMAC_MSG_WORDS)) ? win[0] : sched_new;
          if (round == 7'(`SHAMAC_MSG_WORDS) - 7'h01) begin
            // Window already holds words 0..15 in order
            for (int i = 0; i < 16; i++) begin
              next_win[i] = win[i];
            end
          end
        end
        if (round == `SHAMAC_LAST_ROUND) begin
          next_state = SHAMAC_DONE;
          next_done  = 1'b1;
          next_busy  = 1'b0;
          if (op == SHAMAC_OP_SECRET) begin
            next_secret = {work_rnd.e, work_rnd.d};
            next_load   = 1'b1;
            next_valid  = 1'b0;
          end else begin
            next_code  = {work_rnd.a, work_rnd.b, work_rnd.c, work_rnd.d, work_rnd.e};
            next_valid = 1'b1;
          end
        end else begin
          next_round = round + 7'h01;
        end
      end
      default: begin
        next_state = SHAMAC_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Synchronous reset clears every output so the host sees a clean idle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state               <= SHAMAC_IDLE;
      op                  <= SHAMAC_OP_CODE;
      round               <= 7'h00;
      work                <= '0;
      authentication_code <= '0;
      code_valid          <= 1'b0;
      secret              <= '0;
      secret_load         <= 1'b0;
      done                <= 1'b0;
      busy                <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        win[i] <= 32'h0;
      end
    end else begin
      state               <= next_state;
      op                  <= next_op;
      round               <= next_round;
      work                <= next_work;
      authentication_code <= next_code;
      code_valid          <= next_valid;
      secret              <= next_secret;
      secret_load         <= next_load;
      done                <= next_done;
      busy                <= next_busy;
      for (int i = 0; i < 16; i++) begin
        win[i] <= next_win[i];
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Done rises on the eightieth edge after start, so it is sampled one edge later
  a_done_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.start && state != SHAMAC_RUN) |-> ##81 done)
    else $error("done not exactly eighty cycles after start");

  a_done_not_early: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.start && state != SHAMAC_RUN) |=> !done [*8])
    else $error("done rose too early");

  a_secret_hidden: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (op == SHAMAC_OP_SECRET && done) |-> !code_valid && authentication_code == '0)
    else $error("code exposed in secret mode");

  a_secret_copy: assert property (@(posedge sys_clk) disable iff (!reset_n)
    secret_load |-> secret == {$past(work_rnd.e), $past(work_rnd.d)})
    else $error("secret not copied from E and D");

  a_code_words: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(code_valid) |-> authentication_code == {work.a, work.b, work.c, work.d, work.e})
    else $error("code differs from final working words");

  a_round_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == SHAMAC_RUN && round != `SHAMAC_LAST_ROUND) |=> round == $past(round) + 7'h01)
    else $error("round did not advance by one");

  a_init_words: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.start && state != SHAMAC_RUN) |=> work.a == `SHAMAC_INIT_A && work.e == `SHAMAC_INIT_E)
    else $error("working words not initialised");

  a_shift_words: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == SHAMAC_RUN) |=> work.b == $past(work.a) && work.e == $past(work.d))
    else $error("working words did not shift");

  a_result_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (done && !req.start) |=> $stable(authentication_code) && done)
    else $error("result changed before next start");

  a_first_sched: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == SHAMAC_RUN && round < 7'h10) |-> sched == win[round[3:0]])
    else $error("early schedule word not a message word");

  a_k_group: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == SHAMAC_RUN && round == 7'h00) |-> rsum == {work.a[26:0], work.a[31:27]}
      + ((work.b & work.c) | (~work.b & work.d)) + sched + `SHAMAC_K0 + work.e)
    else $error("first round sum wrong");

  // No result and no secret strobe while rounds are still running
  a_quiet_running: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state == SHAMAC_RUN) |-> !done && !code_valid && !secret_load)
    else $error("result shown before the last round");

  // Busy mirrors the running state exactly
  a_busy_running: assert property (@(posedge sys_clk) disable iff (!reset_n)
    busy == (state == SHAMAC_RUN))
    else $error("busy does not match the running state");

  // An accepted start restarts the round count at zero
  a_start_round: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (req.start && state != SHAMAC_RUN) |=> state == SHAMAC_RUN && round == 7'h00 && busy)
    else $error("start did not begin at round zero");

  // The secret load strobe lasts a single cycle
  a_load_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    secret_load |=> !secret_load)
    else $error("secret load longer than one cycle");

  // The secret register only moves at the end of a run
  a_secret_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state != SHAMAC_RUN) |=> $stable(secret))
    else $error("secret changed outside a run");

  // A valid code only follows a code-mode run
  a_valid_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    code_valid |-> op == SHAMAC_OP_CODE && done)
    else $error("code valid outside code mode");

  // Working words rest between runs
  a_words_rest: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state != SHAMAC_RUN && !req.start) |=> $stable(work))
    else $error("working words moved while idle");

endmodule

// ==== sim/shamac_cmd_model.sv ====
// Command-side model that hands message blocks and start pulses to the engine
`timescale 1ns/10ps

module shamac_cmd_model
  import shamac_pkg::*;
(
  // Clock
  input  wire logic          sys_clk,
  // Orders from the bench
  input  wire logic          go,
  input  wire shamac_op_type op_in,
  input  wire logic [511:0]  msg_in,
  // Toward the engine
  output shamac_req_type     req,
  output logic [511:0]       message
);
  // ****************************************
  // Request driver
  // ****************************************
  initial begin
    req = '0;
    message = '0;
  end

  // Drive on the falling edge; scramble op and words outside a start
  always @(negedge sys_clk) begin
    if (go) begin
      req.start <= 1'b1;
      req.op <= op_in;
      message <= msg_in;
    end else begin
      req.start <= 1'b0;
      req.op <= shamac_op_type'(~req.op);
      message <= ~message;
    end
  end
endmodule

// ==== sim/tb_sha1_mac_engine.sv ====
// Self-checking bench for the single-block hash engine
`timescale 1ns/10ps

module tb_sha1_mac_engine
  import shamac_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic           sys_clk;
  logic           reset_n;
  logic           go;
  shamac_op_type  op_in;
  logic [511:0]   msg_in;
  shamac_req_type req;
  logic [511:0]   message;
  logic           busy;
  logic           done;
  logic [159:0]   authentication_code;
  logic           code_valid;
  logic [63:0]    secret;
  logic           secret_load;
  logic [63:0]    last_secret;  // Secret expected to be held
  int             fail_count;
  int             checked;

  shamac_cmd_model model (.sys_clk(sys_clk), .go(go), .op_in(op_in), .msg_in(msg_in),
    .req(req), .message(message));

  shamac_engine #(.WORD_W(32), .ROUNDS(80)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .req(req), .message(message), .busy(busy), .done(done),
    .authentication_code(authentication_code), .code_valid(code_valid),
    .secret(secret), .secret_load(secret_load));

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // About 530 cycles of work; cut off well beyond it
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  // Reference compression, no feed-forward
  function automatic logic [159:0] ref_code(input logic [511:0] m);
    logic [31:0] w[80];
    logic [31:0] a, b, c, d, e, f, k, t;
    a = 32'h67452301;
    b = 32'hEFCDAB89;
    c = 32'h98BADCFE;
    d = 32'h10325476;
    e = 32'hC3D2E1F0;
    for (int i = 0; i < 80; i++) begin
      if (i < 16) begin
        w[i] = m[511-32*i -: 32];
      end else begin
        t = w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16];
        w[i] = {t[30:0], t[31]};
      end
      if (i < 20) begin
        f = (b & c) | (~b & d);
        k = 32'h5A827999;
      end else if (i < 40) begin
        f = b ^ c ^ d;
        k = 32'h6ED9EBA1;
      end else if (i < 60) begin
        f = (b & c) | (b & d) | (c & d);
        k = 32'h8F1BBCDC;
      end else begin
        f = b ^ c ^ d;
        k = 32'hCA62C1D6;
      end
      t = {a[26:0], a[31:27]} + f + w[i] + k + e;
      e = d;
      d = c;
      c = {b[1:0], b[31:2]};
      b = a;
      a = t;
    end
    return {a, b, c, d, e};
  endfunction

  // One start, optional refused start at cycle 10, full result check
  task automatic do_run(input shamac_op_type op, input logic [511:0] msg, input bit intr);
    logic [159:0] exp;
    int n;
    exp = ref_code(msg);
    @(posedge sys_clk);
    go <= 1'b1;
    op_in <= op;
    msg_in <= msg;
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
    chk("busy_start", 1, busy);
    chk("code_cleared", 0, {done, code_valid, authentication_code});
    for (n = 1; n < 90; n++) begin
      @(posedge sys_clk);
      #1;
      if (intr && n == 10) begin
        go = 1'b1;
        op_in = SHAMAC_OP_SECRET;
        msg_in = ~msg;
      end
      if (n == 11) go = 1'b0;
      if (done) break;
      if (secret_load !== 1'b0) chk("early_load", 0, secret_load);
    end
    chk("rounds", 80, n);
    chk("busy_end", 0, busy);
    if (op == SHAMAC_OP_SECRET) begin
      last_secret = {exp[31:0], exp[63:32]};
      chk("code_hidden", 0, {code_valid, authentication_code});
      chk("load_pulse", 1, secret_load);
    end else begin
      chk("code", exp, authentication_code);
      chk("valid", 1, code_valid);
      chk("no_load", 0, secret_load);
    end
    chk("secret", last_secret, secret);
    @(posedge sys_clk);
    #1;
    chk("load_once", 0, secret_load);
    chk("done_holds", 1, done);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_values();
    chk("reset_outs", 0, {busy, done, code_valid, secret_load, secret, authentication_code});
  endtask

  task automatic code_abc();
    do_run(SHAMAC_OP_CODE, {32'h61626380, 448'h0, 32'h00000018}, 0);
  endtask

  task automatic secret_then_code();
    do_run(SHAMAC_OP_SECRET, {16{32'hFFFFFFFF}}, 0);
    do_run(SHAMAC_OP_CODE, {16{32'h80000001}}, 0);
  endtask

  task automatic refused_start();
    do_run(SHAMAC_OP_CODE, {8{64'h0123456789ABCDEF}}, 1);
  endtask

  task automatic reset_mid_run();
    @(posedge sys_clk);
    go <= 1'b1;
    op_in <= SHAMAC_OP_CODE;
    msg_in <= {16{32'h5A5AA5A5}};
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b0;
    @(negedge sys_clk);
    reset_n = 1'b1;
    last_secret = '0;
    reset_values();
    repeat (90) @(negedge sys_clk);
    chk("no_done", 0, {busy, done});
    do_run(SHAMAC_OP_SECRET, {16{32'h00010203}}, 0);
  endtask

  // ****************************************
  // Main sequence and verdict
  // ****************************************
  task automatic report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    go = 1'b0;
    op_in = SHAMAC_OP_CODE;
    msg_in = '0;
    last_secret = '0;
    fail_count = 0;
    checked = 0;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    reset_values();
    code_abc();
    secret_then_code();
    refused_start();
    reset_mid_run();
    report_and_stop();
  end
endmodule
